// >>> verification/sideband_monitor.sv
// Checker for the sideband wires and the processor end
`timescale 1ns/1ps
`default_nettype none
module sideband_monitor (
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       power_good,
    input wire logic       cpu_only_reset_n,
    input wire logic       cat_dev_oe,
    input wire logic       cat_plat_oe,
    input wire logic [2:0] io_error_n,
    input wire logic       mem_thermal_ch_low_dev_oe,
    input wire logic       mem_thermal_ch_high_plat_oe,
    input wire logic       UNRECOVERABLE_ERR,
    input wire logic       LEGACY_MC_ERR,
    input wire logic [2:0] IO_ERR_EVENT,
    input wire logic [1:0] LEVEL_MODE,
    input wire logic [1:0] BRANCH_HOT,
    input wire logic       MACHINE_CHECK,
    input wire logic [3:0] THROTTLE_CHAN,
    input wire logic       CORE_RESET_N,
    input wire logic       LINK_RESET_N
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    AST_CAT_DRIVE: assert property (
        UNRECOVERABLE_ERR || LEGACY_MC_ERR |=> cat_dev_oe)
        else $error("error line not driven");
    AST_CAT_HOLD: assert property (
        LEGACY_MC_ERR |=> cat_dev_oe [*8])
        else $error("legacy error line not held");
    AST_RESET_IDLE: assert property (
        $rose(NRST) |-> !cat_dev_oe && io_error_n == 3'h7
            && !mem_thermal_ch_low_dev_oe)
        else $error("lines not released after reset");
    AST_EXT_CHECK: assert property (
        cat_plat_oe && !cat_dev_oe && power_good
        ##1 cat_plat_oe && !cat_dev_oe |=> MACHINE_CHECK)
        else $error("external error not taken");
    AST_CAT_GATED: assert property (
        !power_good [*3] |-> !MACHINE_CHECK)
        else $error("error line taken before power good");
    AST_SEVERITY: assert property (
        1'b1 |=> io_error_n == ~$past(IO_ERR_EVENT))
        else $error("severity outputs wrong");
    AST_HOT_LEVEL: assert property (
        1'b1 |=> mem_thermal_ch_low_dev_oe
            == ($past(LEVEL_MODE[0]) && $past(BRANCH_HOT[0])))
        else $error("hot level output wrong");
    AST_THROTTLE_ON: assert property (
        (mem_thermal_ch_high_plat_oe && !LEVEL_MODE[1]) [*2]
        |=> THROTTLE_CHAN[3:2] == 2'h3)
        else $error("upper channels not throttled");
    AST_CORE_RESET: assert property (
        1'b1 |=> CORE_RESET_N == $past(cpu_only_reset_n) && LINK_RESET_N)
        else $error("processor reset wrong");

    cover property (MACHINE_CHECK);
    cover property (THROTTLE_CHAN == 4'hc);
    cover property (cat_dev_oe && !cat_plat_oe);
endmodule
`default_nettype wire

// >>> verification/test_sideband_boot_error_signals.sv
// Bench driving both sideband ends back to back
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module test_sideband_boot_error_signals;
    localparam int DIV = 2; // Short sync bits keep the run brief
    logic       clk = 0, nrst = 0, st_done, go, unrec, legacy;
    logic       st_en, svc, agent, sup_ok, cpu_req, f_cat, run_st;
    logic       booted, leg, agp, pcie, mc, core_n, link_n, cat_seen;
    logic [1:0] sock, regulator_overtemp, lvl, br_hot, hot_seen;
    logic [2:0] io_ev, io_seen, flow;
    logic [3:0] pm_word, pm_st, thr;
    int         miscompares = 0;
    int         samples_checked = 0;
    sideband_if sb ();

    always #50 clk = ~clk;

    // ****************************************
    // Ends and checker
    // ****************************************
    sideband_device #(.CONFIG_CYCLES(8), .SYNC_DIV(DIV)) i_sideband_device (
        .CLK(clk), .NRST(nrst), .SB(sb.device), .SELF_TEST_DONE(st_done),
        .GO_HANDSHAKE(go), .UNRECOVERABLE_ERR(unrec), .LEGACY_MC_ERR(legacy),
        .IO_ERR_EVENT(io_ev), .LEVEL_MODE(lvl), .BRANCH_HOT(br_hot),
        .RUN_SELF_TEST(run_st), .BOOTED(booted), .BOOT_FLOW(flow),
        .IS_LEGACY_SOCKET(leg), .AGENT_PRESENT(agp), .LINKS_PCIE_MODE(pcie),
        .MACHINE_CHECK(mc), .THROTTLE_CHAN(thr), .CORE_RESET_N(core_n),
        .LINK_RESET_N(link_n), .PM_STATUS(pm_st));
    sideband_platform #(.SYNC_DIV(DIV)) i_sideband_platform (
        .CLK(clk), .NRST(nrst), .SB(sb.platform), .SELF_TEST_EN(st_en),
        .SERVICE_BOOT(svc), .AGENT(agent), .SOCKET(sock), .SUPPLIES_OK(sup_ok),
        .CPU_RESET_REQ(cpu_req), .FORCE_CAT(f_cat), .REGULATOR_OVERTEMP(regulator_overtemp),
        .PM_WORD(pm_word), .CAT_SEEN(cat_seen), .IO_ERR_SEEN(io_seen),
        .MEM_HOT_SEEN(hot_seen));
    sideband_monitor i_sideband_monitor (
        .CLK(clk), .NRST(nrst), .power_good(sb.power_good),
        .cpu_only_reset_n(sb.cpu_only_reset_n), .cat_dev_oe(sb.cat_dev_oe),
        .cat_plat_oe(sb.cat_plat_oe), .io_error_n(sb.io_error_n),
        .mem_thermal_ch_low_dev_oe(sb.mem_thermal_ch_low_dev_oe),
        .mem_thermal_ch_high_plat_oe(sb.mem_thermal_ch_high_plat_oe),
        .UNRECOVERABLE_ERR(unrec), .LEGACY_MC_ERR(legacy), .IO_ERR_EVENT(io_ev),
        .LEVEL_MODE(lvl), .BRANCH_HOT(br_hot), .MACHINE_CHECK(mc),
        .THROTTLE_CHAN(thr), .CORE_RESET_N(core_n), .LINK_RESET_N(link_n));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Straps set during reset, since capture is at release
    task automatic boot(input logic s, v, a, input logic [1:0] k);
        int         n;
        logic       seen;
        logic [2:0] ef;
        seen = 0;
        ef = v ? 3'h3 : (a && k == 2'h0) ? 3'h0 : (!a && k[0]) ? 3'h1 : 3'h2;
        {st_en, svc, agent, sock, sup_ok, go, st_done} = {s, v, a, k, 3'h0};
        nrst = 0;
        tick(20);
        nrst = 1;
        f_cat = 1;
        tick(6);
        `CHK("mc gated", 1'b0, mc)
        f_cat = 0;
        tick(4);
        sup_ok = 1;
        for (n = 0; n < 300 && !booted; n++) begin
            seen = seen | run_st;
            st_done = seen;
            go = (n >= 100);
            tick(1);
        end
        `CHK("booted", 1'b1, booted)
        `CHK("stall", v, n > 100)
        `CHK("self test", s, seen)
        `CHK("flow", ef, flow)
        `CHK("legacy", a && k == 2'h0, leg)
        `CHK("agent", a, agp)
        `CHK("pcie", a && k != 2'h0, pcie)
        {st_en, svc, agent, sock} = ~{s, v, a, k};
        tick(4);
        `CHK("held", ef, flow)
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {unrec, legacy, io_ev, lvl, br_hot, regulator_overtemp, cpu_req, f_cat} = '0;
        pm_word = 4'h0;
        for (int i = 0; i < 24; i++) begin
            boot(i[0], i[1], i[2], 2'(i / 8));
        end
        f_cat = 1;
        tick(4);
        `CHK("ext cat", 1'b1, mc)
        `CHK("cat seen", 1'b1, cat_seen)
        f_cat = 0;
        tick(4);
        unrec = 1;
        tick(1);
        `CHK("own cat", 1'b0, sb.catastrophic_error_n)
        unrec = 0;
        tick(2);
        `CHK("released", 1'b1, sb.catastrophic_error_n)
        `CHK("no own mc", 1'b0, mc)
        legacy = 1;
        tick(1);
        legacy = 0;
        tick(20);
        `CHK("legacy hold", 1'b0, sb.catastrophic_error_n)
        for (int i = 0; i < 3; i++) begin
            io_ev = 3'(1 << i);
            tick(2);
            `CHK("sev", ~io_ev, sb.io_error_n)
            `CHK("sev seen", io_ev, io_seen)
        end
        io_ev = 3'h0;
        for (int p = 0; p < 2; p++) begin
            regulator_overtemp = 2'(1 << p);
            tick(4);
            `CHK("throttle", p ? 4'hc : 4'h3, thr)
            `CHK("hot seen", regulator_overtemp, hot_seen)
            regulator_overtemp = 2'h0;
            lvl = 2'h3;
            br_hot = 2'(1 << p);
            tick(3);
            `CHK("hot out", ~br_hot, {sb.mem_thermal_ch_high_n,
                sb.mem_thermal_ch_low_n})
            lvl = 2'h0;
            br_hot = 2'h0;
            tick(4);
        end
        cpu_req = 1;
        tick(3);
        `CHK("core rst", 1'b0, core_n)
        `CHK("link rst", 1'b1, link_n)
        cpu_req = 0;
        tick(3);
        `CHK("core run", 1'b1, core_n)
        for (int w = 0; w < 16; w++) begin
            pm_word = 4'(w);
            tick(12 * DIV);
            `CHK("pm", pm_word, pm_st)
        end
        end_sim;
    end

    // Far longer than the whole sequence needs
    initial begin
        tick(20000);
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire

// >>> verilog/sideband_device.sv
// Processor end of the asynchronous sideband signals
`timescale 1ns/1ps
`default_nettype none
module sideband_device #(
    parameter int CONFIG_CYCLES = sideband_pkg::CONFIG_CYCLES,
    parameter int SYNC_DIV      = sideband_pkg::SYNC_DIV
) (
    input  wire logic                                CLK,
    input  wire logic                                NRST,
    sideband_if.device                               SB,
    input  wire logic                                SELF_TEST_DONE,
    input  wire logic                                GO_HANDSHAKE,
    input  wire logic                                UNRECOVERABLE_ERR,
    input  wire logic                                LEGACY_MC_ERR,
    input  wire logic [sideband_pkg::ERR_SEV_W-1:0]  IO_ERR_EVENT,
    input  wire logic [sideband_pkg::HOT_PINS-1:0]   LEVEL_MODE,
    input  wire logic [sideband_pkg::HOT_PINS-1:0]   BRANCH_HOT,
    output logic                                     RUN_SELF_TEST,
    output logic                                     BOOTED,
    output logic [2:0]                               BOOT_FLOW,
    output logic                                     IS_LEGACY_SOCKET,
    output logic                                     AGENT_PRESENT,
    output logic                                     LINKS_PCIE_MODE,
    output logic                                     MACHINE_CHECK,
    output logic [sideband_pkg::CHAN_W-1:0]          THROTTLE_CHAN,
    output logic                                     CORE_RESET_N,
    output logic                                     LINK_RESET_N,
    output logic [sideband_pkg::PM_STATUS_W-1:0]     PM_STATUS
);

    // ************************************************************
    // Strap capture
    // ************************************************************
    logic                              captured;
    logic                              st_strap;
    logic                              sp_strap;
    logic                              fa_strap;
    logic [sideband_pkg::SOCKET_W-1:0] sock;
    logic                              pg;
    logic                              cat_in;
    logic [sideband_pkg::HOT_PINS-1:0] hot_in;

    // Single capture after release; values frozen until reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            captured <= 1'b0;
            st_strap <= 1'b0;
            sp_strap <= 1'b0;
            fa_strap <= 1'b0;
            sock     <= '0;
        end else if (!captured) begin  // RULE_18
            captured <= 1'b1;
            st_strap <= SB.self_test_strap;
            sp_strap <= SB.service_proc_boot_strap;
            fa_strap <= SB.firmware_agent_strap;
            sock     <= SB.socket_number;
        end
    end

    // ************************************************************
    // Boot flow decode
    // ************************************************************
    wire legacy   = fa_strap && (sock == sideband_pkg::LEGACY_SOCKET);
    wire one_hop  = !fa_strap && (sock[0] == 1'b1);
    sideband_pkg::boot_flow_t flow;
    // Flow depends on the service, agent and socket straps together
    assign flow = sp_strap ? sideband_pkg::BOOT_SERVICE_PROC  // RULE_02
                : legacy   ? sideband_pkg::BOOT_LOCAL         // RULE_03
                : one_hop  ? sideband_pkg::BOOT_LINK_ONE_HOP
                :            sideband_pkg::BOOT_LINK_MULTI_HOP;

    // ************************************************************
    // Boot sequencer
    // ************************************************************
    sideband_pkg::boot_state_t state;
    sideband_pkg::boot_state_t next_state;
    logic [7:0] cfg_cnt;

    always_comb begin
        next_state = state;
        case (state)
            sideband_pkg::ST_POWER_WAIT:
                if (captured && pg) begin
                    next_state = st_strap ? sideband_pkg::ST_SELF_TEST
                                          : sideband_pkg::ST_MIN_CONFIG;
                end  // RULE_01
            sideband_pkg::ST_SELF_TEST:
                if (SELF_TEST_DONE) begin
                    next_state = sideband_pkg::ST_MIN_CONFIG;
                end
            sideband_pkg::ST_MIN_CONFIG:
                if (cfg_cnt == 8'(CONFIG_CYCLES - 1)) begin
                    next_state = sp_strap ? sideband_pkg::ST_WAIT_GO
                                          : sideband_pkg::ST_RUN;
                end  // RULE_04
            sideband_pkg::ST_WAIT_GO:
                if (GO_HANDSHAKE) begin  // RULE_04
                    next_state = sideband_pkg::ST_RUN;
                end
            sideband_pkg::ST_RUN:
                next_state = sideband_pkg::ST_RUN;
            default:
                next_state = sideband_pkg::ST_POWER_WAIT;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state   <= sideband_pkg::ST_POWER_WAIT;
            cfg_cnt <= 8'h00;
        end else begin
            state   <= next_state;
            cfg_cnt <= (state == sideband_pkg::ST_MIN_CONFIG)
                     ? cfg_cnt + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RUN_SELF_TEST    <= 1'b0;
            BOOTED           <= 1'b0;
            BOOT_FLOW        <= 3'h0;
            IS_LEGACY_SOCKET <= 1'b0;
            AGENT_PRESENT    <= 1'b0;
            LINKS_PCIE_MODE  <= 1'b0;
        end else begin
            RUN_SELF_TEST    <= (next_state == sideband_pkg::ST_SELF_TEST);
            BOOTED           <= (next_state == sideband_pkg::ST_RUN);
            BOOT_FLOW        <= 3'(flow);
            IS_LEGACY_SOCKET <= legacy;                     // RULE_05
            AGENT_PRESENT    <= fa_strap;                   // RULE_05
            LINKS_PCIE_MODE  <= fa_strap && !legacy;        // RULE_05
        end
    end

    // ************************************************************
    // Catastrophic error
    // ************************************************************
    logic cat_drive;
    logic cat_held;
    // Own drive masked one cycle late, in step with the sampled line
    wire  ext_cat = pg && !cat_in && !cat_drive;  // RULE_08

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pg       <= 1'b0;
            cat_in   <= 1'b1;
            hot_in   <= '1;
            cat_held <= 1'b0;
            cat_drive     <= 1'b0;
            MACHINE_CHECK <= 1'b0;
            SB.cat_dev_oe <= 1'b0;
        end else begin
            pg     <= SB.power_good;
            cat_in <= SB.catastrophic_error_n;
            hot_in <= {SB.mem_thermal_ch_high_n, SB.mem_thermal_ch_low_n};
            if (LEGACY_MC_ERR) begin
                cat_held <= 1'b1;  // RULE_09
            end
            cat_drive     <= SB.cat_dev_oe;
            // Drive only low; release otherwise
            SB.cat_dev_oe <= UNRECOVERABLE_ERR | LEGACY_MC_ERR
                           | cat_held;  // RULE_06 RULE_10
            MACHINE_CHECK <= ext_cat;   // RULE_07
        end
    end

    // ************************************************************
    // I/O unit severity and memory thermal pins
    // ************************************************************
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SB.io_error_n                 <= '1;
            THROTTLE_CHAN                 <= '0;
            SB.mem_thermal_ch_low_dev_oe  <= 1'b0;
            SB.mem_thermal_ch_high_dev_oe <= 1'b0;
        end else begin
            SB.io_error_n <= ~IO_ERR_EVENT;  // RULE_12
            // Input mode throttles the pin's channel pair
            THROTTLE_CHAN <= {{2{~LEVEL_MODE[1] & ~hot_in[1]}},
                              {2{~LEVEL_MODE[0] & ~hot_in[0]}}};  // RULE_13 RULE_15
            SB.mem_thermal_ch_low_dev_oe  <= LEVEL_MODE[0]
                                           & BRANCH_HOT[0];  // RULE_14
            SB.mem_thermal_ch_high_dev_oe <= LEVEL_MODE[1]
                                           & BRANCH_HOT[1];  // RULE_15
        end
    end

    // ************************************************************
    // Processor-only reset and power sync receiver
    // ************************************************************
    logic [7:0]                           div_cnt;
    logic [sideband_pkg::PM_STATUS_W-1:0] pm_shift;
    logic [2:0]                           bit_cnt;
    wire  tick = (div_cnt == 8'(SYNC_DIV - 1));

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CORE_RESET_N <= 1'b0;
            LINK_RESET_N <= 1'b0;
            div_cnt      <= 8'h00;
            pm_shift     <= '0;
            bit_cnt      <= 3'h0;
            PM_STATUS    <= '0;
        end else begin
            CORE_RESET_N <= SB.cpu_only_reset_n;  // RULE_11
            LINK_RESET_N <= 1'b1;                 // RULE_11
            div_cnt      <= tick ? 8'h00 : div_cnt + 8'h01;
            if (tick) begin  // RULE_16
                pm_shift <= {pm_shift[sideband_pkg::PM_STATUS_W-2:0],
                             SB.power_mgmt_sync};
                bit_cnt  <= (bit_cnt == 3'(sideband_pkg::PM_STATUS_W - 1))
                          ? 3'h0 : bit_cnt + 3'h1;
                // Line lags the sender one tick: last bit lands at 0
                if (bit_cnt == 3'h0) begin
                    PM_STATUS <= {pm_shift[sideband_pkg::PM_STATUS_W-2:0],
                                  SB.power_mgmt_sync};
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> verilog/sideband_if.sv
// Interface joining the processor sideband end and the platform end
`timescale 1ns/1ps
`default_nettype none
interface sideband_if;
    logic                                   self_test_strap;
    logic                                   service_proc_boot_strap;
    logic                                   firmware_agent_strap;
    logic [sideband_pkg::SOCKET_W-1:0]      socket_number;
    logic                                   power_good;
    logic                                   cpu_only_reset_n;
    logic                                   power_mgmt_sync;
    // Open-drain catastrophic error line, split per driver
    logic                                   cat_dev_oe;
    logic                                   cat_plat_oe;
    logic                                   catastrophic_error_n;
    logic [sideband_pkg::ERR_SEV_W-1:0]     io_error_n;
    // Open-drain memory thermal pins
    logic                                   mem_thermal_ch_low_dev_oe;
    logic                                   mem_thermal_ch_high_dev_oe;
    logic                                   mem_thermal_ch_low_plat_oe;
    logic                                   mem_thermal_ch_high_plat_oe;
    logic                                   mem_thermal_ch_low_n;
    logic                                   mem_thermal_ch_high_n;

    // Wired-OR resolution of the open-drain lines
    assign catastrophic_error_n  = ~(cat_dev_oe | cat_plat_oe);
    assign mem_thermal_ch_low_n  = ~(mem_thermal_ch_low_dev_oe
                                   | mem_thermal_ch_low_plat_oe);
    assign mem_thermal_ch_high_n = ~(mem_thermal_ch_high_dev_oe
                                   | mem_thermal_ch_high_plat_oe);

    modport device (
        input  self_test_strap, service_proc_boot_strap,
        input  firmware_agent_strap, socket_number, power_good,
        input  cpu_only_reset_n, power_mgmt_sync,
        input  catastrophic_error_n, mem_thermal_ch_low_n,
        input  mem_thermal_ch_high_n,
        output cat_dev_oe, io_error_n,
        output mem_thermal_ch_low_dev_oe, mem_thermal_ch_high_dev_oe
    );
    modport platform (
        output self_test_strap, service_proc_boot_strap,
        output firmware_agent_strap, socket_number, power_good,
        output cpu_only_reset_n, power_mgmt_sync,
        output cat_plat_oe,
        output mem_thermal_ch_low_plat_oe, mem_thermal_ch_high_plat_oe,
        input  catastrophic_error_n, io_error_n,
        input  mem_thermal_ch_low_n, mem_thermal_ch_high_n
    );
endinterface
`default_nettype wire

// >>> verilog/sideband_pkg.sv
// Shared constants and types for the processor sideband signals
// ****************************************************************
// Summary of operation
// (RULE_01) Run self test only when strap enables
// (RULE_02) Boot flow from three straps combined
// (RULE_03) Service strap low: local, one-hop, multi-hop boot
// (RULE_04) Service strap high: stall until go handshake
// (RULE_05) Agent strap plus socket: legacy, agent, link mode
// (RULE_06) Drive catastrophic error on unrecoverable errors
// (RULE_07) External catastrophic assertion raises machine check
// (RULE_08) Catastrophic input ignored until power good
// (RULE_09) Legacy machine check holds line until reset
// (RULE_10) Wired-OR line: drive low only, else release
// (RULE_11) Processor reset leaves chipset links running
// (RULE_12) Three active-low I/O unit severity outputs
// (RULE_13) Input mode: external hot pin throttles channels
// (RULE_14) Output mode: pin asserted while branch hot
// (RULE_15) Low pin channels 0,1; high pin channels 2,3
// (RULE_16) Chipset sends power status on one sync line
// (RULE_17) Power good only when clock, supplies stable
// (RULE_18) Straps latched at reset release, held constant
// ****************************************************************
package sideband_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int SOCKET_W       = 2;
    localparam int PM_STATUS_W    = 4;
    localparam int ERR_SEV_W      = 3;
    localparam int SEV_CORRECTED  = 0;
    localparam int SEV_NONFATAL   = 1;
    localparam int SEV_FATAL      = 2;
    localparam int CHAN_W         = 4;
    localparam int HOT_PINS       = 2;
    localparam int SYNC_DIV       = 10;
    localparam int CONFIG_CYCLES  = 8;
    localparam logic [SOCKET_W-1:0] LEGACY_SOCKET = 2'h0;

    // ************************************************************
    // Boot flows
    // ************************************************************
    typedef enum logic [2:0] {
        BOOT_LOCAL,
        BOOT_LINK_ONE_HOP,
        BOOT_LINK_MULTI_HOP,
        BOOT_SERVICE_PROC
    } boot_flow_t;

    // Boot sequencer states
    typedef enum logic [2:0] {
        ST_POWER_WAIT,
        ST_SELF_TEST,
        ST_MIN_CONFIG,
        ST_WAIT_GO,
        ST_RUN
    } boot_state_t;

endpackage

// >>> verilog/sideband_platform.sv
// Platform end: straps, power good, error line and power sync sender
`timescale 1ns/1ps
`default_nettype none
module sideband_platform #(
    parameter int SYNC_DIV = sideband_pkg::SYNC_DIV
) (
    input  wire logic                                  CLK,
    input  wire logic                                  NRST,
    sideband_if.platform                               SB,
    input  wire logic                                  SELF_TEST_EN,
    input  wire logic                                  SERVICE_BOOT,
    input  wire logic                                  AGENT,
    input  wire logic [sideband_pkg::SOCKET_W-1:0]     SOCKET,
    input  wire logic                                  SUPPLIES_OK,
    input  wire logic                                  CPU_RESET_REQ,
    input  wire logic                                  FORCE_CAT,
    input  wire logic [sideband_pkg::HOT_PINS-1:0]     REGULATOR_OVERTEMP,
    input  wire logic [sideband_pkg::PM_STATUS_W-1:0]  PM_WORD,
    output logic                                       CAT_SEEN,
    output logic [sideband_pkg::ERR_SEV_W-1:0]         IO_ERR_SEEN,
    output logic [sideband_pkg::HOT_PINS-1:0]          MEM_HOT_SEEN
);

    logic [7:0] div_cnt;
    logic [2:0] bit_cnt;
    logic [sideband_pkg::PM_STATUS_W-1:0] word;
    wire  tick = (div_cnt == 8'(SYNC_DIV - 1));

    // No reset: straps must be valid before the device's release
    always_ff @(posedge CLK) begin
        SB.self_test_strap         <= SELF_TEST_EN;
        SB.service_proc_boot_strap <= SERVICE_BOOT;
        SB.firmware_agent_strap    <= AGENT;
        SB.socket_number           <= SOCKET;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SB.power_good              <= 1'b0;
            SB.cpu_only_reset_n        <= 1'b0;
            SB.cat_plat_oe             <= 1'b0;
            SB.mem_thermal_ch_low_plat_oe  <= 1'b0;
            SB.mem_thermal_ch_high_plat_oe <= 1'b0;
            CAT_SEEN     <= 1'b0;
            IO_ERR_SEEN  <= '0;
            MEM_HOT_SEEN <= '0;
        end else begin
            SB.power_good              <= SUPPLIES_OK;  // RULE_17
            SB.cpu_only_reset_n        <= ~CPU_RESET_REQ;
            SB.cat_plat_oe             <= FORCE_CAT;    // RULE_07 RULE_10
            SB.mem_thermal_ch_low_plat_oe  <= REGULATOR_OVERTEMP[0];  // RULE_13
            SB.mem_thermal_ch_high_plat_oe <= REGULATOR_OVERTEMP[1];
            CAT_SEEN     <= ~SB.catastrophic_error_n;
            IO_ERR_SEEN  <= ~SB.io_error_n;
            MEM_HOT_SEEN <= {~SB.mem_thermal_ch_high_n,
                             ~SB.mem_thermal_ch_low_n};
        end
    end

    // Serial power status, MSB first, one bit per divider tick
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            div_cnt            <= 8'h00;
            bit_cnt            <= 3'h0;
            word               <= '0;
            SB.power_mgmt_sync <= 1'b0;
        end else begin
            div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
            if (tick) begin  // RULE_16
                if (bit_cnt == 3'h0) begin
                    word               <= {PM_WORD[sideband_pkg::PM_STATUS_W-2:0],
                                           1'b0};
                    SB.power_mgmt_sync <= PM_WORD[sideband_pkg::PM_STATUS_W-1];
                end else begin
                    word               <= {word[sideband_pkg::PM_STATUS_W-2:0],
                                           1'b0};
                    SB.power_mgmt_sync <= word[sideband_pkg::PM_STATUS_W-1];
                end
                bit_cnt <= (bit_cnt == 3'(sideband_pkg::PM_STATUS_W - 1))
                         ? 3'h0 : bit_cnt + 3'h1;
            end
        end
    end

endmodule
`default_nettype wire
